// File: verification/sector_ecc_sva.sv
// Port assertions for the sector check-code block
`timescale 1ns/1ps
module sector_ecc_sva (
   input wire logic clock,
   input wire logic srst,
   input wire logic start,
   input wire logic busy,
   input wire logic done,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic out_kind,
   input wire logic [9:0] out_addr,
   input wire logic [7:0] out_data,
   input wire logic error_free,
   input wire logic correctable,
   input wire logic uncorrectable,
   input wire logic [10:0] err_pattern
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   chk_done_end: assert property (done |-> !busy && $past(busy))
      else $error("done not at end");
   chk_done_pulse: assert property (done |=> !done)
      else $error("done too long");
   chk_status_one: assert property (done |->
      $onehot0({error_free, correctable, uncorrectable})) else $error("status clash");
   chk_start_clear: assert property (start && !busy |=> busy && !error_free
      && !correctable && !uncorrectable) else $error("start not taken");
   chk_ready_busy: assert property (in_ready |-> busy)
      else $error("ready while idle");
   chk_out_hold: assert property (out_valid && !out_ready |=> out_valid
      && $stable({out_kind, out_addr, out_data})) else $error("entry lost");
   chk_fix_addr: assert property (out_valid && out_kind |-> out_addr < 10'h200)
      else $error("fix outside data");
   chk_byte_index: assert property (out_valid && !out_kind |-> out_addr < 10'h007)
      else $error("bad check index");
   chk_status_hold: assert property (!busy && !start |=>
      $stable({error_free, correctable, uncorrectable})) else $error("status moved");
   chk_pat_anchor: assert property (done && correctable |-> err_pattern[0])
      else $error("pattern not anchored");
endmodule : sector_ecc_sva
bind sector_ecc sector_ecc_sva i_sva (.clock, .srst, .start, .busy, .done, .in_ready,
   .out_valid, .out_ready, .out_kind, .out_addr, .out_data, .error_free, .correctable,
   .uncorrectable, .err_pattern);

// File: verification/sector_sink.sv
// Sector buffer side model that takes entries with stalls
`timescale 1ns/1ps
module sector_sink (
   input wire logic clock,
   input wire logic stall,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic out_kind,
   input wire logic [9:0] out_addr,
   input wire logic [7:0] out_data
);
   logic [18:0] got [$];
   logic [1:0] cnt_reg = 2'h0;
   always @(posedge clock) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (out_valid && out_ready) got.push_back({out_kind, out_addr, out_data});
   end
   assign out_ready = !stall || cnt_reg == 2'h3;
endmodule : sector_sink

// File: verification/tb_sector_ecc.sv
// Bench for the sector check-code block
`timescale 1ns/1ps
module tb_sector_ecc;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic start = 1'b0;
   logic write_mode = 1'b0;
   logic long_check = 1'b0;
   logic in_valid = 1'b0;
   logic [7:0] in_data = 8'h00;
   logic stall = 1'b0;
   logic in_ready, out_valid, out_ready, out_kind, busy, done, error_free, correctable;
   logic uncorrectable;
   logic [9:0] out_addr;
   logic [7:0] out_data;
   logic [12:0] err_location;
   logic [10:0] err_pattern;
   logic [7:0] rec [0:518];
   int bad_count = 0;
   int checks = 0;
   sector_ecc i_dut (.clock, .srst, .start, .write_mode, .long_check, .in_valid, .in_ready,
      .in_data, .out_valid, .out_ready, .out_kind, .out_addr, .out_data, .busy, .done,
      .error_free, .correctable, .uncorrectable, .err_location, .err_pattern);
   sector_sink i_sink (.clock, .stall, .out_valid, .out_ready, .out_kind, .out_addr, .out_data);
   initial begin
      forever #25 clock = ~clock;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done;
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : test_done
   task automatic fill;
      logic [55:0] r;
      r = 56'h0;
      for (int i = 0; i < 4096; i++) begin
         rec[i / 8] = 8'(i / 8) ^ 8'h5a;
         r = {r[54:0], 1'b0} ^ ((rec[i / 8][7 - i % 8] ^ r[55]) ?
            sector_ecc_pkg::FWD_POLY_LOW : 56'h0);
      end
      for (int k = 0; k < 7; k++) rec[512 + k] = r[55 - 8 * k -: 8];
      i_sink.got.delete();
   endtask : fill
   task automatic op(input logic wm, input logic lc);
      int i;
      logic t;
      i = 0;
      start = 1'b1;
      write_mode = wm;
      long_check = lc;
      @(negedge clock);
      start = 1'b0;
      in_valid = 1'b1;
      while (i < (wm ? 512 : (lc ? 519 : 516))) begin
         in_data = rec[i];
         t = in_ready;
         @(negedge clock);
         if (t) i++;
      end
      in_valid = 1'b0;
      for (int w = 0; w < 5000 && !done; w++) @(negedge clock);
      check("done", done, 1);
      repeat (8) @(negedge clock);
   endtask : op
   task automatic rd(input logic lc, input logic [2:0] st, input int nfix);
      op(1'b0, lc);
      check("status", {error_free, correctable, uncorrectable}, st);
      check("fixes", i_sink.got.size(), nfix);
   endtask : rd
   task automatic t_write(input logic lc);
      fill();
      stall = 1'b1;
      op(1'b1, lc);
      stall = 1'b0;
      check("count", i_sink.got.size(), lc ? 7 : 4);
      foreach (i_sink.got[k]) check("chk", i_sink.got[k], {1'b0, 10'(k), rec[512 + k]});
   endtask : t_write
   task automatic t_burst;
      fill();
      rec[100] ^= 8'h07;
      rec[101] ^= 8'hf0;
      rd(1'b1, 3'h2, 2);
      check("fix0", i_sink.got[0], {1'b1, 10'h065, 8'hf0});
      check("fix1", i_sink.got[1], {1'b1, 10'h064, 8'h07});
      check("loc", err_location, 13'h0d0c);
      check("pat", err_pattern, 11'h07f);
      fill();
      rec[518] ^= 8'h01;
      rd(1'b1, 3'h2, 0);
      check("loc", err_location, 13'h0000);
   endtask : t_burst
   task automatic t_bad;
      fill();
      rd(1'b1, 3'h4, 0);
      rd(1'b0, 3'h4, 0);
      rec[10] ^= 8'h80;
      rec[13] ^= 8'h01;
      rd(1'b1, 3'h1, 0);
      fill();
      rec[50] ^= 8'h01;
      rec[400] ^= 8'h80;
      rd(1'b1, 3'h1, 0);
      fill();
      rec[3] ^= 8'h01;
      rd(1'b0, 3'h1, 0);
   endtask : t_bad
   initial begin
      repeat (4) @(negedge clock);
      srst = 1'b0;
      @(negedge clock);
      t_write(1'b1);
      t_write(1'b0);
      t_burst();
      t_bad();
      test_done();
   end
   initial begin
      repeat (60000) @(posedge clock);
      bad_count++;
      test_done();
   end
endmodule : tb_sector_ecc

// File: verilog/ecc_pair_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ecc_pair_buffer #(
   parameter int WIDTH = 19
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot_reg [2];
   logic [WIDTH-1:0] slot_next [2];
   logic wr_reg, wr_next, rd_reg, rd_next;
   logic [1:0] fill_reg, fill_next;
   logic push, pop;

   assign in_ready = (fill_reg != 2'h2);
   assign out_valid = (fill_reg != 2'h0);
   assign out_data = slot_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      slot_next = slot_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      fill_next = fill_reg;
      if (push) begin
         slot_next[wr_reg] = in_data;
         wr_next = ~wr_reg;
      end
      if (pop) begin
         rd_next = ~rd_reg;
      end
      if (push && !pop) begin
         fill_next = fill_reg + 2'h1;
      end else if (pop && !push) begin
         fill_next = fill_reg - 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         slot_reg[0] <= '0;
         slot_reg[1] <= '0;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         fill_reg <= 2'h0;
      end else begin
         slot_reg <= slot_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         fill_reg <= fill_next;
      end
   end
endmodule : ecc_pair_buffer

// File: verilog/sector_ecc.sv
// Sector check-code generator, syndrome checker and burst corrector
`timescale 1ns/1ps
// Notes on behaviour
// - Divide by degree-56 forward generator polynomial
// - Reciprocal polynomial locates the error burst
// - Record is at most 519 bytes
// - Data field is exactly 512 bytes
// - Correct single bursts up to 11 bits with the 7-byte check field only
// - Longer single bursts flagged, never miscorrected
// - Double bursts flagged as uncorrectable
// - Command selects 7-byte or 4-byte check field
// - Corrections applied to buffer memory bytes
module sector_ecc (
   input wire logic clock,
   input wire logic srst,
   input wire logic start,
   input wire logic write_mode,
   input wire logic long_check,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic out_kind,
   output logic [9:0] out_addr,
   output logic [7:0] out_data,
   output logic busy,
   output logic done,
   output logic error_free,
   output logic correctable,
   output logic uncorrectable,
   output logic [12:0] err_location,
   output logic [10:0] err_pattern
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_DATA = 7'b0000010,
      ST_EMIT = 7'b0000100,
      ST_CHECK = 7'b0001000,
      ST_EVAL = 7'b0010000,
      ST_TRAP = 7'b0100000,
      ST_FIX = 7'b1000000
   } state_t;

   state_t state_reg, state_next;
   logic [55:0] rem_reg, rem_next, rev;
   logic [12:0] cnt_reg, cnt_next, loc_reg, loc_next;
   logic [10:0] pat_reg, pat_next;
   logic wr_reg, wr_next, long_reg, long_next, mis_reg, mis_next;
   logic free_reg, free_next, fix_reg, fix_next, bad_reg, bad_next;
   logic done_reg, done_next;
   logic push_valid, push_ready;
   logic [sector_ecc_pkg::BUF_WIDTH-1:0] push_word, pop_word;
   logic [31:0] wide;
   logic [7:0] fix_mask;
   logic [10:0] fix_sum, fix_addr;
   logic fix_use;
   logic [12:0] chk_last;

   // Forward division, one byte per cycle
   function automatic logic [55:0] div_byte(input logic [55:0] r, input logic [7:0] d);
      logic [55:0] acc;
      logic fb;
      acc = r;
      for (int i = 7; i >= 0; i--) begin
         fb = acc[55] ^ d[i];
         acc = {acc[54:0], 1'b0} ^ (fb ? sector_ecc_pkg::FWD_POLY_LOW : 56'h0);
      end
      return acc;
   endfunction : div_byte

   // Bit-reversed view of the remainder
   for (genvar i = 0; i < 56; i++) begin : g_rev
      assign rev[i] = rem_reg[55 - i];
   end

   // Byte address and mask for each touched byte
   assign wide = {21'h0, pat_reg} << loc_reg[2:0];
   assign fix_mask = wide[{cnt_reg[1:0], 3'b000} +: 8];
   assign fix_sum = {1'b0, loc_reg[12:3]} + {9'h0, cnt_reg[1:0]};
   assign fix_addr = sector_ecc_pkg::RECORD_LAST_BYTE - fix_sum;
   assign fix_use = (fix_sum <= sector_ecc_pkg::RECORD_LAST_BYTE)
      && (fix_addr[9:0] < sector_ecc_pkg::DATA_BYTES) && !fix_addr[10] && (fix_mask != 8'h0);
   // Check field length from the mode
   assign chk_last = long_reg ? sector_ecc_pkg::CHK_LONG_LAST : sector_ecc_pkg::CHK_SHORT_LAST;

   always_comb begin
      state_next = state_reg;
      rem_next = rem_reg;
      cnt_next = cnt_reg;
      loc_next = loc_reg;
      pat_next = pat_reg;
      wr_next = wr_reg;
      long_next = long_reg;
      mis_next = mis_reg;
      free_next = free_reg;
      fix_next = fix_reg;
      bad_next = bad_reg;
      done_next = 1'b0;
      in_ready = 1'b0;
      push_valid = 1'b0;
      push_word = {sector_ecc_pkg::OUT_CHECK, cnt_reg[9:0], rem_reg[55:48]};
      unique case (state_reg)
         ST_IDLE: begin
            if (start) begin
               wr_next = write_mode;
               long_next = long_check;
               rem_next = 56'h0;
               cnt_next = 13'h0;
               mis_next = 1'b0;
               free_next = 1'b0;
               fix_next = 1'b0;
               bad_next = 1'b0;
               loc_next = 13'h0;
               pat_next = 11'h0;
               state_next = ST_DATA;
            end
         end
         ST_DATA: begin
            in_ready = 1'b1;
            if (in_valid) begin
               rem_next = div_byte(rem_reg, in_data);
               cnt_next = cnt_reg + 13'h1;
               if (cnt_reg == sector_ecc_pkg::DATA_LAST) begin
                  cnt_next = 13'h0;
                  state_next = wr_reg ? ST_EMIT : ST_CHECK;
               end
            end
         end
         ST_EMIT: begin
            push_valid = 1'b1;
            if (push_ready) begin
               rem_next = {rem_reg[47:0], 8'h0};
               cnt_next = cnt_reg + 13'h1;
               if (cnt_reg == chk_last) begin
                  done_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         ST_CHECK: begin
            in_ready = 1'b1;
            if (in_valid) begin
               if (long_reg) begin
                  rem_next = div_byte(rem_reg, in_data);
               end else begin
                  rem_next = {rem_reg[47:0], 8'h0};
                  mis_next = mis_reg | (in_data != rem_reg[55:48]);
               end
               cnt_next = cnt_reg + 13'h1;
               if (cnt_reg == chk_last) begin
                  state_next = ST_EVAL;
               end
            end
         end
         ST_EVAL: begin
            cnt_next = 13'h0;
            if (long_reg ? (rem_reg == 56'h0) : !mis_reg) begin
               free_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end else if (!long_reg) begin
               bad_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               rem_next = rev;
               state_next = ST_TRAP;
            end
         end
         ST_TRAP: begin
            // Burst trapped in low 11 syndrome bits
            // Pattern bit 0 set pins the lowest error bit
            if ((rev[55:11] == 45'h0) && rev[0]
               && (cnt_reg >= sector_ecc_pkg::TRAP_OFFSET)) begin
               loc_next = cnt_reg - sector_ecc_pkg::TRAP_OFFSET;
               pat_next = rev[10:0];
               cnt_next = 13'h0;
               state_next = ST_FIX;
            // No trap within record means uncorrectable
            end else if (cnt_reg == sector_ecc_pkg::TRAP_LAST) begin
               bad_next = 1'b1;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               // Reciprocal shift steps back one bit
               rem_next = {rem_reg[54:0], 1'b0}
                  ^ (rem_reg[55] ? sector_ecc_pkg::RECIP_POLY_LOW : 56'h0);
               cnt_next = cnt_reg + 13'h1;
            end
         end
         ST_FIX: begin
            push_valid = fix_use;
            push_word = {sector_ecc_pkg::OUT_FIX, fix_addr[9:0], fix_mask};
            if (!fix_use || push_ready) begin
               cnt_next = cnt_reg + 13'h1;
               if (cnt_reg[1:0] == sector_ecc_pkg::FIX_LAST) begin
                  fix_next = 1'b1;
                  done_next = 1'b1;
                  state_next = ST_IDLE;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         rem_reg <= 56'h0;
         cnt_reg <= 13'h0;
         loc_reg <= 13'h0;
         pat_reg <= 11'h0;
         wr_reg <= 1'b0;
         long_reg <= 1'b0;
         mis_reg <= 1'b0;
         free_reg <= 1'b0;
         fix_reg <= 1'b0;
         bad_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rem_reg <= rem_next;
         cnt_reg <= cnt_next;
         loc_reg <= loc_next;
         pat_reg <= pat_next;
         wr_reg <= wr_next;
         long_reg <= long_next;
         mis_reg <= mis_next;
         free_reg <= free_next;
         fix_reg <= fix_next;
         bad_reg <= bad_next;
         done_reg <= done_next;
      end
   end

   // Check bytes and corrections leave through the buffer
   ecc_pair_buffer #(
      .WIDTH(sector_ecc_pkg::BUF_WIDTH)
   ) u_buffer (
      .clock(clock),
      .srst(srst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_word),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(pop_word)
   );

   assign out_kind = pop_word[18];
   assign out_addr = pop_word[17:8];
   assign out_data = pop_word[7:0];
   assign busy = (state_reg != ST_IDLE);
   assign done = done_reg;
   assign error_free = free_reg;
   assign correctable = fix_reg;
   assign uncorrectable = bad_reg;
   assign err_location = loc_reg;
   assign err_pattern = pat_reg;
endmodule : sector_ecc

// File: verilog/sector_ecc_pkg.sv
// Constants shared by the sector check-code logic
package sector_ecc_pkg;
   localparam logic [12:0] DATA_LAST = 13'h01ff;
   localparam logic [12:0] CHK_LONG_LAST = 13'h0006;
   localparam logic [12:0] CHK_SHORT_LAST = 13'h0003;
   localparam logic [55:0] FWD_POLY_LOW = 56'h140a0445000101;
   localparam logic [55:0] RECIP_POLY_LOW = 56'h0100014440a051;
   localparam logic [12:0] TRAP_OFFSET = 13'h0038;
   localparam logic [12:0] TRAP_LAST = 13'h106f;
   localparam logic [10:0] RECORD_LAST_BYTE = 11'h206;
   localparam logic [9:0] DATA_BYTES = 10'h200;
   localparam logic [1:0] FIX_LAST = 2'h2;
   localparam int BUF_WIDTH = 19;
   localparam logic OUT_CHECK = 1'b0;
   localparam logic OUT_FIX = 1'b1;
endpackage : sector_ecc_pkg
